/* File: pmbsc_pkg.sv */
// package: modes, states and timing constants of the power mode and boot strap controller
package pmbsc_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_HZ           = 125_000_000;
  localparam int unsigned BOOT_TIME_US     = 100;
  localparam int unsigned BOOT_CYCLES      = (BOOT_TIME_US * (CLK_HZ / 1_000_000));
  localparam int unsigned CNT_W            = 32;
  localparam int unsigned SCALE_DIV        = 8;
  localparam int unsigned SCALE_W          = 3;
  localparam int unsigned BANNER_LEN       = 8;
  localparam int unsigned BANNER_IDX_W     = 3;

  // ****************************************************************
  // boot strap positions
  // ****************************************************************
  localparam int unsigned STRAP_SRC        = 0;
  localparam int unsigned STRAP_PRINT      = 1;
  localparam int unsigned STRAP_RAIL       = 2;
  localparam int unsigned STRAP_W          = 3;
  localparam logic [2:0]  STRAP_DEFAULT    = 3'h7;

  // ****************************************************************
  // stop wake sources
  // ****************************************************************
  typedef enum logic [1:0] {
    PMBSC_WAKE_GPIO  = 2'h0,
    PMBSC_WAKE_TIMER = 2'h1,
    PMBSC_WAKE_LINK  = 2'h2
  } pmbsc_wake_t;

  // ****************************************************************
  // power modes seen outside (no sleep mode exists)
  // ****************************************************************
  typedef enum logic [1:0] {
    PMBSC_MODE_RESET   = 2'h0,
    PMBSC_MODE_ACTIVE  = 2'h1,
    PMBSC_MODE_STANDBY = 2'h2,
    PMBSC_MODE_STOP    = 2'h3
  } pmbsc_mode_t;

  // ****************************************************************
  // sequencer states, gray along boot -> banner -> active -> standby -> stop
  // ****************************************************************
  typedef enum logic [2:0] {
    PMBSC_ST_BOOT    = 3'h0,
    PMBSC_ST_BANNER  = 3'h1,
    PMBSC_ST_ACTIVE  = 3'h3,
    PMBSC_ST_STANDBY = 3'h2,
    PMBSC_ST_STOP    = 3'h6
  } pmbsc_state_t;

  localparam logic [7:0] BANNER_BYTE [BANNER_LEN] = '{
    8'h2b, 8'h53, 8'h54, 8'h41, 8'h52, 8'h54, 8'h55, 8'h50
  };

endpackage

/* File: pmbsc_strap_if.sv */
// interface: latched boot strap levels passed from the latch to the sequencer
`timescale 1ns/100ps
interface pmbsc_strap_if;
  logic       valid;
  logic [2:0] level;
  modport latch (output valid, output level);
  modport user  (input  valid, input  level);
endinterface

/* File: pmbsc_strap_latch.sv */
// module: captures the boot strap pins once after reset release and again after each reboot
`timescale 1ns/100ps
module pmbsc_strap_latch (
  // clock and reset
  input  wire logic   clk_i,
  input  wire logic   rst_i,
  input  wire logic   reboot_i,
  // strap pins
  input  wire logic [2:0] pins_i,
  // latched values
  pmbsc_strap_if.latch    strap
);

  logic       valid_q;
  logic       valid_d;
  logic [2:0] level_q;
  logic [2:0] level_d;

  // ****************************************************************
  // capture
  // ****************************************************************
  // the reset only loads a constant; the pin levels are taken on the first
  // clock after release or after a reboot, then frozen until the next one
  always_comb begin
    valid_d = valid_q;
    level_d = level_q;
    if (reboot_i) begin
      valid_d = 1'b0;
    end else if (!valid_q) begin
      valid_d = 1'b1;
      level_d = pins_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      valid_q <= 1'b0;
      level_q <= pmbsc_pkg::STRAP_DEFAULT;
    end else begin
      valid_q <= valid_d;
      level_q <= level_d;
    end
  end

  assign strap.valid = valid_q;
  assign strap.level = level_q;

endmodule

/* File: pmbsc_ctrl.sv */
// module: power mode, reboot and boot strap sequencer (top)
`timescale 1ns/100ps
module pmbsc_ctrl #(
  parameter int unsigned BOOT_CYCLES = pmbsc_pkg::BOOT_CYCLES,
  parameter int unsigned GPIO_W      = 3
) (
  // clock and reset
  input  wire logic                REF_CLK_I,
  input  wire logic                RST_I,
  // reboot pin, open drain with internal pull-up
  input  wire logic                REBOOT_N_I,
  output logic                     REBOOT_N_O,
  output logic                     REBOOT_N_OE_N_O,
  // host commands; soft reboot and stop are one-cycle pulses
  input  wire logic                SOFT_REBOOT_CMD_I,
  input  wire logic                STOP_CMD_I,
  input  wire logic                STOP_TIMER_EN_I,
  input  wire logic [31:0]         STOP_DELAY_I,
  input  wire logic [GPIO_W-1:0]   WAKE_GPIO_SEL_I,
  input  wire logic [GPIO_W-1:0]   WAKE_GPIO_I,
  // configuration
  input  wire logic                LINK_STOP_SETTING_I,
  input  wire logic                AUTO_CLOCK_SCALING_I,
  input  wire logic                COMMAND_MODE_I,
  // activity
  input  wire logic                WORK_PENDING_I,
  input  wire logic                LINK_STATUS_I,
  // strap pins, shared with spi chip select and data out
  input  wire logic [2:0]          STRAP_PINS_I,
  input  wire logic                SPI_DATA_OUT_I,
  output logic                     SPI_DATA_OUT_O,
  output logic                     SPI_DATA_OUT_OE_N_O,
  output logic                     SPI_CS_O,
  // status
  output logic [1:0]               POWER_MODE_O,
  output logic                     CORE_RUN_O,
  output logic                     CLK_EN_O,
  output logic                     RAM_RETAIN_O,
  output logic                     LINKS_KEEP_O,
  output logic                     FACTORY_BOOT_O,
  output logic                     FLASH_RAIL_1V8_O,
  output logic                     SOFT_RESET_O,
  output logic                     HARD_RESET_O,
  // ready banner
  output logic                     TX_VALID_O,
  output logic [7:0]               TX_DATA_O,
  input  wire logic                TX_READY_I,
  output logic                     BOOT_TX_EN_O
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  pmbsc_strap_if strap ();

  pmbsc_pkg::pmbsc_state_t state_q;
  pmbsc_pkg::pmbsc_state_t state_d;
  pmbsc_pkg::pmbsc_wake_t  wake_src_q;
  pmbsc_pkg::pmbsc_wake_t  wake_src_d;
  logic [31:0]                       cnt_q;
  logic [31:0]                       cnt_d;
  logic [pmbsc_pkg::BANNER_IDX_W-1:0] bidx_q;
  logic [pmbsc_pkg::BANNER_IDX_W-1:0] bidx_d;
  logic [GPIO_W-1:0]                 gpio_ref_q;
  logic [GPIO_W-1:0]                 gpio_ref_d;
  logic [pmbsc_pkg::SCALE_W-1:0]     div_q;
  logic [pmbsc_pkg::SCALE_W-1:0]     div_d;
  logic                              link_q;
  logic                              reboot_req;
  logic                              wake;
  logic                              soft_q;
  logic                              hard_q;
  logic                              stop_enter;
  logic                              link_wake_q;
  logic                              link_wake_d;

  // ****************************************************************
  // outputs registered
  // ****************************************************************
  logic [1:0] mode_q;
  logic [1:0] mode_d;
  logic       run_q;
  logic       run_d;
  logic       clk_en_q;
  logic       clk_en_d;
  logic       tx_valid_q;
  logic       tx_valid_d;
  logic [7:0] tx_data_q;
  logic [7:0] tx_data_d;
  logic       boot_tx_q;
  logic       boot_tx_d;
  logic       cs_q;
  logic       miso_q;
  logic       miso_oe_n_q;
  logic       miso_oe_n_d;

  function automatic logic gpio_changed(input logic [GPIO_W-1:0] now,
                                        input logic [GPIO_W-1:0] ref_lvl,
                                        input logic [GPIO_W-1:0] sel);
    gpio_changed = |((now ^ ref_lvl) & sel);
  endfunction

  pmbsc_strap_latch u_strap (
    .clk_i    (REF_CLK_I),
    .rst_i    (RST_I),
    .reboot_i (reboot_req),
    .pins_i   (STRAP_PINS_I),
    .strap    (strap.latch)
  );

  // ****************************************************************
  // reboot sources
  // ****************************************************************
  // a low reboot pin or soft command restarts the sequence from boot;
  // wake from stop also reboots rather than resuming
  assign reboot_req = !REBOOT_N_I || SOFT_REBOOT_CMD_I || wake;

  assign stop_enter = STOP_CMD_I || (LINK_STOP_SETTING_I && link_q && !LINK_STATUS_I);

  assign link_wake_d = LINK_STOP_SETTING_I && LINK_STATUS_I;

  always_comb begin
    wake = 1'b0;
    if (state_q == pmbsc_pkg::PMBSC_ST_STOP) begin
      case (wake_src_q)
        pmbsc_pkg::PMBSC_WAKE_GPIO: begin
          wake = gpio_changed(WAKE_GPIO_I, gpio_ref_q, WAKE_GPIO_SEL_I);
        end
        pmbsc_pkg::PMBSC_WAKE_TIMER: begin
          wake = (cnt_q == 32'h0000_0000);
        end
        pmbsc_pkg::PMBSC_WAKE_LINK: begin
          wake = link_wake_q;
        end
        default: begin
          wake = 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_comb begin
    state_d    = state_q;
    wake_src_d = wake_src_q;
    cnt_d      = cnt_q;
    bidx_d     = bidx_q;
    gpio_ref_d = gpio_ref_q;
    tx_valid_d = tx_valid_q;
    tx_data_d  = tx_data_q;
    if (reboot_req) begin
      state_d    = pmbsc_pkg::PMBSC_ST_BOOT;
      cnt_d      = 32'h0000_0000;
      bidx_d     = '0;
      tx_valid_d = 1'b0;
    end else begin
      case (state_q)
        pmbsc_pkg::PMBSC_ST_BOOT: begin
          cnt_d = cnt_q + 32'h0000_0001;
          if (cnt_q >= 32'(BOOT_CYCLES - 1)) begin
            cnt_d = 32'h0000_0000;
            if (COMMAND_MODE_I) begin
              state_d    = pmbsc_pkg::PMBSC_ST_BANNER;
              tx_valid_d = 1'b1;
              tx_data_d  = pmbsc_pkg::BANNER_BYTE[0];
            end else begin
              state_d = pmbsc_pkg::PMBSC_ST_ACTIVE;
            end
          end
        end
        pmbsc_pkg::PMBSC_ST_BANNER: begin
          if (TX_READY_I) begin
            if (bidx_q == pmbsc_pkg::BANNER_IDX_W'(pmbsc_pkg::BANNER_LEN - 1)) begin
              tx_valid_d = 1'b0;
              state_d    = pmbsc_pkg::PMBSC_ST_ACTIVE;
            end else begin
              bidx_d    = bidx_q + 1'b1;
              tx_data_d = pmbsc_pkg::BANNER_BYTE[bidx_q + 1'b1];
            end
          end
        end
        pmbsc_pkg::PMBSC_ST_ACTIVE, pmbsc_pkg::PMBSC_ST_STANDBY: begin
          if (stop_enter) begin
            state_d    = pmbsc_pkg::PMBSC_ST_STOP;
            gpio_ref_d = WAKE_GPIO_I;
            cnt_d      = STOP_DELAY_I;
            if (!STOP_CMD_I) begin
              wake_src_d = pmbsc_pkg::PMBSC_WAKE_LINK;
            end else if (STOP_TIMER_EN_I) begin
              wake_src_d = pmbsc_pkg::PMBSC_WAKE_TIMER;
            end else begin
              wake_src_d = pmbsc_pkg::PMBSC_WAKE_GPIO;
            end
          end else if (WORK_PENDING_I) begin
            state_d = pmbsc_pkg::PMBSC_ST_ACTIVE;
          end else begin
            state_d = pmbsc_pkg::PMBSC_ST_STANDBY;
          end
        end
        pmbsc_pkg::PMBSC_ST_STOP: begin
          if (wake_src_q == pmbsc_pkg::PMBSC_WAKE_TIMER && cnt_q != 32'h0000_0000) begin
            cnt_d = cnt_q - 32'h0000_0001;
          end
        end
        default: begin
          state_d = pmbsc_pkg::PMBSC_ST_BOOT;
        end
      endcase
    end
  end

  // ****************************************************************
  // mode, clock and pin outputs
  // ****************************************************************
  always_comb begin
    div_d = div_q + 1'b1;
    if (div_q == pmbsc_pkg::SCALE_W'(pmbsc_pkg::SCALE_DIV - 1)) begin
      div_d = '0;
    end
  end

  always_comb begin
    mode_d      = pmbsc_pkg::PMBSC_MODE_RESET;
    run_d       = 1'b0;
    clk_en_d    = 1'b0;
    boot_tx_d   = 1'b0;
    miso_oe_n_d = 1'b1;
    case (state_d)
      pmbsc_pkg::PMBSC_ST_BOOT: begin
        run_d     = 1'b1;
        clk_en_d  = 1'b1;
        boot_tx_d = strap.level[pmbsc_pkg::STRAP_PRINT];
      end
      pmbsc_pkg::PMBSC_ST_BANNER, pmbsc_pkg::PMBSC_ST_ACTIVE: begin
        mode_d      = pmbsc_pkg::PMBSC_MODE_ACTIVE;
        run_d       = 1'b1;
        clk_en_d    = 1'b1;
        miso_oe_n_d = 1'b0;
      end
      pmbsc_pkg::PMBSC_ST_STANDBY: begin
        mode_d      = pmbsc_pkg::PMBSC_MODE_STANDBY;
        run_d       = 1'b1;
        miso_oe_n_d = 1'b0;
        // scaled clock may limit top uart rate while idling
        clk_en_d    = AUTO_CLOCK_SCALING_I ? (div_q == '0) : 1'b1;
      end
      pmbsc_pkg::PMBSC_ST_STOP: begin
        mode_d = pmbsc_pkg::PMBSC_MODE_STOP;
      end
      default: begin
        mode_d = pmbsc_pkg::PMBSC_MODE_RESET;
      end
    endcase
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_q     <= pmbsc_pkg::PMBSC_ST_BOOT;
      wake_src_q  <= pmbsc_pkg::PMBSC_WAKE_GPIO;
      cnt_q       <= 32'h0000_0000;
      bidx_q      <= '0;
      gpio_ref_q  <= '0;
      div_q       <= '0;
      link_q      <= 1'b1;
      link_wake_q <= 1'b0;
      soft_q      <= 1'b0;
      hard_q      <= 1'b1;
      mode_q      <= pmbsc_pkg::PMBSC_MODE_RESET;
      run_q       <= 1'b0;
      clk_en_q    <= 1'b0;
      tx_valid_q  <= 1'b0;
      tx_data_q   <= 8'h00;
      boot_tx_q   <= 1'b0;
      cs_q        <= 1'b1;
      miso_q      <= 1'b0;
      miso_oe_n_q <= 1'b1;
    end else begin
      state_q     <= state_d;
      wake_src_q  <= wake_src_d;
      cnt_q       <= cnt_d;
      bidx_q      <= bidx_d;
      gpio_ref_q  <= gpio_ref_d;
      div_q       <= div_d;
      link_q      <= LINK_STATUS_I;
      link_wake_q <= link_wake_d;
      soft_q      <= SOFT_REBOOT_CMD_I;
      hard_q      <= !REBOOT_N_I;
      mode_q      <= mode_d;
      run_q       <= run_d;
      clk_en_q    <= clk_en_d;
      tx_valid_q  <= tx_valid_d;
      tx_data_q   <= tx_data_d;
      boot_tx_q   <= boot_tx_d;
      cs_q        <= STRAP_PINS_I[pmbsc_pkg::STRAP_PRINT];
      miso_q      <= SPI_DATA_OUT_I;
      miso_oe_n_q <= miso_oe_n_d;
    end
  end

  // ****************************************************************
  // port drive
  // ****************************************************************
  // reboot pin is input only; the pull-up is modelled by never enabling
  assign REBOOT_N_O          = 1'b1;
  assign REBOOT_N_OE_N_O     = 1'b1;
  assign POWER_MODE_O        = mode_q;
  assign CORE_RUN_O          = run_q;
  assign CLK_EN_O            = clk_en_q;
  assign RAM_RETAIN_O        = run_q;
  assign LINKS_KEEP_O        = run_q;
  assign FACTORY_BOOT_O      = ~strap.level[pmbsc_pkg::STRAP_SRC];
  assign FLASH_RAIL_1V8_O    = strap.level[pmbsc_pkg::STRAP_RAIL];
  assign SOFT_RESET_O        = soft_q;
  assign HARD_RESET_O        = hard_q;
  assign TX_VALID_O          = tx_valid_q;
  assign TX_DATA_O           = tx_data_q;
  assign BOOT_TX_EN_O        = boot_tx_q;
  assign SPI_CS_O            = cs_q;
  assign SPI_DATA_OUT_O      = miso_q;
  assign SPI_DATA_OUT_OE_N_O = miso_oe_n_q;

endmodule

/* File: pmbsc_host_model.sv */
// host side model: open-drain reboot pull, strap pin levels and banner flow control
`timescale 1ns/100ps
module pmbsc_host_model (
  // clock
  input  wire logic       clk_i,
  // bench controls
  input  wire logic       pull_reboot_i,
  input  wire logic [1:0] strap_low_i,
  input  wire logic       slow_ready_i,
  // device pins
  input  wire logic       dev_reboot_n_i,
  input  wire logic       dev_reboot_oe_n_i,
  input  wire logic       dev_do_i,
  input  wire logic       dev_do_oe_n_i,
  output logic            reboot_n_o,
  output logic [2:0]      straps_o,
  output logic            tx_ready_o
);
  logic ready_q = 1'h1;
  // the host only sinks the line; the idle level comes from the pull-up
  assign reboot_n_o = !pull_reboot_i && (dev_reboot_oe_n_i || dev_reboot_n_i);
  // never pulled low from outside; a released pin rises to its pull-up
  assign straps_o[2] = dev_do_oe_n_i ? 1'h1 : dev_do_i;
  // left to the pull-ups unless a test deliberately overrides them
  assign straps_o[1:0] = ~strap_low_i;
  // a slow host drops ready on every other clock
  always @(posedge clk_i) begin
    ready_q <= slow_ready_i ? !ready_q : 1'h1;
  end
  assign tx_ready_o = ready_q;
endmodule

/* File: pmbsc_ctrl_asserts.sv */
// checker: timing relations at the controller's ports
`timescale 1ns/100ps
module pmbsc_ctrl_asserts (
  // clock and reset
  input wire logic       REF_CLK_I,
  input wire logic       RST_I,
  // inputs
  input wire logic       REBOOT_N_I,
  input wire logic       SOFT_REBOOT_CMD_I,
  input wire logic       STOP_CMD_I,
  input wire logic       AUTO_CLOCK_SCALING_I,
  input wire logic       TX_READY_I,
  // outputs
  input wire logic [1:0] POWER_MODE_O,
  input wire logic       CORE_RUN_O,
  input wire logic       CLK_EN_O,
  input wire logic       RAM_RETAIN_O,
  input wire logic       LINKS_KEEP_O,
  input wire logic       FACTORY_BOOT_O,
  input wire logic       FLASH_RAIL_1V8_O,
  input wire logic       SOFT_RESET_O,
  input wire logic       HARD_RESET_O,
  input wire logic       TX_VALID_O,
  input wire logic [7:0] TX_DATA_O
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  // ****************************************************************
  // properties
  // ****************************************************************
  property p_soft;
    SOFT_REBOOT_CMD_I |=> SOFT_RESET_O ##[0:1] POWER_MODE_O == 2'h0;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reboot missing");
  property p_hard;
    !REBOOT_N_I [*3] |-> HARD_RESET_O && POWER_MODE_O == 2'h0;
  endproperty
  a_hard: assert property (p_hard) else $error("reboot pin not obeyed");
  // guards keep out cycles where a reboot is already under way or the banner is still being sent
  property p_stop_in;
    STOP_CMD_I && POWER_MODE_O inside {2'h1, 2'h2} && REBOOT_N_I && !SOFT_REBOOT_CMD_I
      && !SOFT_RESET_O && !HARD_RESET_O && !TX_VALID_O |-> ##[1:2] POWER_MODE_O == 2'h3;
  endproperty
  a_stop_in: assert property (p_stop_in) else $error("stop not entered");
  property p_halt;
    POWER_MODE_O == 2'h3 |-> !CORE_RUN_O && !RAM_RETAIN_O && !LINKS_KEEP_O;
  endproperty
  a_halt: assert property (p_halt) else $error("stop keeps running");
  property p_alive;
    (POWER_MODE_O inside {2'h1, 2'h2}) [*2] |-> CORE_RUN_O && LINKS_KEEP_O && RAM_RETAIN_O;
  endproperty
  a_alive: assert property (p_alive) else $error("links dropped while running");
  property p_full;
    (POWER_MODE_O == 2'h1) [*2] |-> CLK_EN_O;
  endproperty
  a_full: assert property (p_full) else $error("active clock gated");
  property p_scale;
    (POWER_MODE_O == 2'h2 && AUTO_CLOCK_SCALING_I) [*3] |-> !(CLK_EN_O && $past(CLK_EN_O));
  endproperty
  a_scale: assert property (p_scale) else $error("scaled clock not reduced");
  property p_wake;
    POWER_MODE_O == 2'h3 ##1 POWER_MODE_O != 2'h3 |-> POWER_MODE_O == 2'h0;
  endproperty
  a_wake: assert property (p_wake) else $error("wake without reboot");
  property p_latch;
    (POWER_MODE_O != 2'h0) [*2] |-> $stable(FACTORY_BOOT_O) && $stable(FLASH_RAIL_1V8_O);
  endproperty
  a_latch: assert property (p_latch) else $error("strap value moved");
  property p_banner;
    TX_VALID_O && !TX_READY_I && REBOOT_N_I && !SOFT_REBOOT_CMD_I
      |=> TX_VALID_O && $stable(TX_DATA_O);
  endproperty
  a_banner: assert property (p_banner) else $error("banner byte dropped");
endmodule
bind pmbsc_ctrl pmbsc_ctrl_asserts chk_u (
  .REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .REBOOT_N_I(REBOOT_N_I),
  .SOFT_REBOOT_CMD_I(SOFT_REBOOT_CMD_I), .STOP_CMD_I(STOP_CMD_I),
  .AUTO_CLOCK_SCALING_I(AUTO_CLOCK_SCALING_I), .TX_READY_I(TX_READY_I),
  .POWER_MODE_O(POWER_MODE_O), .CORE_RUN_O(CORE_RUN_O), .CLK_EN_O(CLK_EN_O),
  .RAM_RETAIN_O(RAM_RETAIN_O), .LINKS_KEEP_O(LINKS_KEEP_O), .FACTORY_BOOT_O(FACTORY_BOOT_O),
  .FLASH_RAIL_1V8_O(FLASH_RAIL_1V8_O), .SOFT_RESET_O(SOFT_RESET_O),
  .HARD_RESET_O(HARD_RESET_O), .TX_VALID_O(TX_VALID_O), .TX_DATA_O(TX_DATA_O));

/* File: pmbsc_ctrl_tb.sv */
// self-checking bench for the power mode and boot strap controller
`timescale 1ns/100ps
module pmbsc_ctrl_tb;
  localparam int unsigned BOOT_N = 4;
  localparam int          LIMIT  = 3000;
  localparam string       BANNER = "+STARTUP";
  typedef struct packed {logic work; logic scale; logic [1:0] md; logic [4:0] pulses;}
    pmbsc_tb_row_t;
  localparam pmbsc_tb_row_t ROWS [5] = '{'{1'h1, 1'h0, 2'h1, 5'h10},
    '{1'h0, 1'h0, 2'h2, 5'h10}, '{1'h0, 1'h1, 2'h2, 5'h02},
    '{1'h1, 1'h1, 2'h1, 5'h10}, '{1'h0, 1'h1, 2'h2, 5'h02}};
  logic        clk = 1'h0, rst = 1'h1, soft_cmd = 1'h0, stop_cmd = 1'h0, timer_en = 1'h0;
  logic        link_set = 1'h0, scale = 1'h0, cmd_mode = 1'h1, work = 1'h1, link = 1'h1;
  logic        spi_do = 1'h1, pull_rb = 1'h0, slow_rdy = 1'h1;
  logic [1:0]  strap_low = 2'h0;
  logic [31:0] delay = 32'h14;
  logic [2:0]  gpio_sel = 3'h2, gpio = 3'h0;
  logic [7:0]  got;
  wire         reboot_n, rb_o, rb_oe_n, do_o, do_oe_n, cs, run, clk_en, retain, keep;
  wire         factory, rail, soft_rst, hard_rst, tx_valid, tx_ready, boot_tx;
  wire [2:0]   straps;
  wire [1:0]   mode;
  wire [7:0]   tx_data;
  int          n_mismatch = 0, total_checks = 0, cycles = 0, cnt;

  pmbsc_ctrl #(.BOOT_CYCLES(BOOT_N), .GPIO_W(3)) dut_u (
    .REF_CLK_I(clk), .RST_I(rst), .REBOOT_N_I(reboot_n), .REBOOT_N_O(rb_o),
    .REBOOT_N_OE_N_O(rb_oe_n), .SOFT_REBOOT_CMD_I(soft_cmd), .STOP_CMD_I(stop_cmd),
    .STOP_TIMER_EN_I(timer_en), .STOP_DELAY_I(delay), .WAKE_GPIO_SEL_I(gpio_sel),
    .WAKE_GPIO_I(gpio), .LINK_STOP_SETTING_I(link_set), .AUTO_CLOCK_SCALING_I(scale),
    .COMMAND_MODE_I(cmd_mode), .WORK_PENDING_I(work), .LINK_STATUS_I(link),
    .STRAP_PINS_I(straps), .SPI_DATA_OUT_I(spi_do), .SPI_DATA_OUT_O(do_o),
    .SPI_DATA_OUT_OE_N_O(do_oe_n), .SPI_CS_O(cs), .POWER_MODE_O(mode), .CORE_RUN_O(run),
    .CLK_EN_O(clk_en), .RAM_RETAIN_O(retain), .LINKS_KEEP_O(keep),
    .FACTORY_BOOT_O(factory), .FLASH_RAIL_1V8_O(rail), .SOFT_RESET_O(soft_rst),
    .HARD_RESET_O(hard_rst), .TX_VALID_O(tx_valid), .TX_DATA_O(tx_data),
    .TX_READY_I(tx_ready), .BOOT_TX_EN_O(boot_tx));
  pmbsc_host_model host_u (
    .clk_i(clk), .pull_reboot_i(pull_rb), .strap_low_i(strap_low), .slow_ready_i(slow_rdy),
    .dev_reboot_n_i(rb_o), .dev_reboot_oe_n_i(rb_oe_n), .dev_do_i(do_o),
    .dev_do_oe_n_i(do_oe_n), .reboot_n_o(reboot_n), .straps_o(straps), .tx_ready_o(tx_ready));

  initial begin
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_mismatch++;
      $display("Error at %0t: run did not finish", $time);
      final_report();
    end
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic chk_val(input logic [31:0] g, input logic [31:0] e, input string what);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error at %0t: %s got %0h exp %0h", $time, what, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e, input string what);
    chk_val({31'h0, g}, {31'h0, e}, what);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wait_mode(input logic [1:0] m, input int lim);
    int i;
    i = 0;
    while (mode !== m && i < lim) begin
      tick(1);
      i++;
    end
    chk_val(mode, m, "mode");
  endtask
  task automatic pulse(input bit is_stop);
    @(posedge clk);
    if (is_stop) stop_cmd <= 1'h1;
    else soft_cmd <= 1'h1;
    @(posedge clk);
    stop_cmd <= 1'h0;
    soft_cmd <= 1'h0;
    #1;
  endtask
  // a byte counts as sent at the edge where valid and ready are both high
  task automatic take_byte(output logic [7:0] d);
    int i;
    i = 0;
    while (!(tx_valid === 1'h1 && tx_ready === 1'h1) && i < 60) begin
      tick(1);
      i++;
    end
    d = tx_data;
    tick(1);
  endtask
  task automatic do_reset();
    rst <= 1'h1;
    tick(3);
    chk_val(mode, 2'h0, "reset mode");
    chk_bit(run, 1'h0, "reset run");
    chk_bit(hard_rst, 1'h1, "reset hard");
    chk_bit(rail, 1'h1, "reset rail");
    @(posedge clk);
    rst <= 1'h0;
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ****************************************************************
  // sequence
  // ****************************************************************
  initial begin
    do_reset();
    tick(2);
    chk_bit(boot_tx, 1'h1, "printout");
    chk_bit(factory, 1'h0, "flash boot");
    for (int b = 0; b < 8; b++) begin
      take_byte(got);
      chk_val(got, BANNER[b], "banner");
    end
    wait_mode(2'h1, 10);
    @(posedge clk);
    strap_low <= 2'h2;
    spi_do <= 1'h0;
    tick(2);
    chk_bit(cs, 1'h0, "chip select");
    chk_bit(do_o, 1'h0, "data out");
    chk_bit(do_oe_n, 1'h0, "data out enable");
    chk_bit(rail, 1'h1, "rail held");
    strap_low <= 2'h0;
    spi_do <= 1'h1;
    // later boots skip the banner, so a stop command is never refused in banner state
    cmd_mode <= 1'h0;
    $display("done: boot and straps");
    foreach (ROWS[r]) begin
      @(posedge clk);
      work <= ROWS[r].work;
      scale <= ROWS[r].scale;
      tick(3);
      chk_val(mode, ROWS[r].md, "row mode");
      cnt = 0;
      repeat (16) begin
        cnt += (clk_en === 1'h1);
        tick(1);
      end
      chk_val(cnt, ROWS[r].pulses, "clock pulses");
      chk_bit(run && keep && retain, 1'h1, "alive");
      $display("done: row %0d", r);
    end
    work <= 1'h1;
    scale <= 1'h0;
    pulse(1);
    wait_mode(2'h3, 2);
    chk_bit(run || keep || retain, 1'h0, "halted");
    @(posedge clk);
    gpio <= 3'h1;
    tick(4);
    chk_val(mode, 2'h3, "unselected pin");
    gpio <= 3'h3;
    wait_mode(2'h0, 4);
    wait_mode(2'h1, 60);
    chk_bit(tx_valid, 1'h0, "no banner");
    @(posedge clk);
    timer_en <= 1'h1;
    pulse(1);
    tick(16);
    chk_val(mode, 2'h3, "timer early");
    wait_mode(2'h0, 8);
    timer_en <= 1'h0;
    link_set <= 1'h1;
    wait_mode(2'h1, 60);
    @(posedge clk);
    link <= 1'h0;
    wait_mode(2'h3, 3);
    link <= 1'h1;
    wait_mode(2'h0, 4);
    link_set <= 1'h0;
    wait_mode(2'h1, 60);
    $display("done: stop modes");
    strap_low <= 2'h3;
    pulse(0);
    chk_bit(soft_rst, 1'h1, "soft reset");
    chk_bit(hard_rst, 1'h0, "not hard");
    pulse(1);
    chk_val(mode, 2'h0, "stop in boot");
    chk_bit(factory, 1'h1, "factory boot");
    chk_bit(boot_tx, 1'h0, "silent boot");
    wait_mode(2'h1, 60);
    chk_bit(factory, 1'h1, "factory held");
    @(posedge clk);
    pull_rb <= 1'h1;
    tick(6);
    chk_bit(hard_rst, 1'h1, "hard reset");
    chk_val(mode, 2'h0, "held in boot");
    chk_bit(rb_oe_n, 1'h1, "pin released");
    chk_bit(rb_o, 1'h1, "pin idle level");
    pull_rb <= 1'h0;
    wait_mode(2'h1, 60);
    chk_bit(factory, 1'h1, "hard relatch");
    // pins back to default so the reset below must relatch a different value
    strap_low <= 2'h0;
    do_reset();
    wait_mode(2'h1, 60);
    chk_bit(factory, 1'h0, "relatched");
    $display("done: reboots");
    final_report();
  end
endmodule
